// ---- scm_pkg.sv ----
// constants and types shared by the serial audio clock monitor
package scm_pkg;
	// register map
	localparam logic [7:0] SCM_STATUS_ADDR   = 8'h71;
	localparam logic [7:0] SCM_STATUS_RESET  = 8'h00;
	// status field positions
	localparam int         SCM_ST_HALT_BIT   = 1;
	localparam int         SCM_ST_RATIO_BIT  = 2;
	localparam int         SCM_ST_ERR_BIT    = 3;
	localparam int         SCM_ST_RATE_LSB   = 5;
	localparam int         SCM_ST_LOCK_BIT   = 7;
	// timing
	localparam int         SCM_CLK_NS        = 20;
	localparam int         SCM_BCLK_TO_NS    = 2000;
	localparam int         SCM_FS_TO_NS      = 40000;
	localparam int         SCM_BCLK_TO_CYC   = SCM_BCLK_TO_NS / SCM_CLK_NS;
	localparam int         SCM_FS_TO_CYC     = SCM_FS_TO_NS / SCM_CLK_NS;
	// frame period limits between rate families
	localparam int         SCM_F192_MAX_NS   = 7800;
	localparam int         SCM_F96_MAX_NS    = 15600;
	localparam int         SCM_F48_MAX_NS    = 26000;
	localparam logic [11:0] SCM_F192_MAX_CYC = 12'(SCM_F192_MAX_NS / SCM_CLK_NS);
	localparam logic [11:0] SCM_F96_MAX_CYC  = 12'(SCM_F96_MAX_NS / SCM_CLK_NS);
	localparam logic [11:0] SCM_F48_MAX_CYC  = 12'(SCM_F48_MAX_NS / SCM_CLK_NS);
	// word size and supported bit clocks per frame
	localparam logic [5:0] SCM_WORD_BITS     = 6'd32;
	localparam logic [9:0] SCM_RATIO_32      = 10'd32;
	localparam logic [9:0] SCM_RATIO_64      = 10'd64;
	localparam logic [9:0] SCM_RATIO_128     = 10'd128;
	localparam logic [9:0] SCM_RATIO_256     = 10'd256;
	localparam logic [9:0] SCM_RATIO_512     = 10'd512;

	typedef enum logic [1:0] {
		SCM_RATE_32K,
		SCM_RATE_48K,
		SCM_RATE_96K,
		SCM_RATE_192K
	} scm_rate_t;

	typedef enum logic [1:0] {
		SCM_WAIT,
		SCM_LOCK,
		SCM_RUN
	} scm_state_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0]  slot;
		logic        chan;
	} scm_word_t;

	typedef struct packed {
		logic       lock;
		logic [1:0] rate;
		logic       rsvd;
		logic       err;
		logic       ratio;
		logic       halt;
		logic       rsvd0;
	} scm_status_t;
endpackage

// ---- scm_monitor.sv ----
// serial audio receive port with rate detect and clock halt monitor
`timescale 1ns/1ns
module scm_monitor
	import scm_pkg::*;
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	// serial audio pins
	input  wire logic             serial_bit_clock,
	input  wire logic             word_frame_sync,
	input  wire logic             serial_audio_in,
	// mode and enable
	input  wire logic             tdm_mode,
	input  wire logic             play_enable,
	// status read port
	input  wire logic [7:0]       reg_addr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	// received words
	output scm_pkg::scm_word_t    word_out,
	output logic                  word_valid,
	// clocking and power state
	output logic                  proc_tick,
	output scm_pkg::scm_rate_t    rate_family,
	output logic                  pll_locked,
	output logic                  dsp_sleep,
	output logic                  amp_oe_n
);
	import scm_pkg::*;

	// supported bit clocks per frame for the format and rate family
	function automatic logic ratio_ok(input logic tdm, input logic [9:0] n, input scm_rate_t r);
		logic ok;
		ok = 1'b0;
		if (!tdm) begin
			ok = (n == SCM_RATIO_32) || (n == SCM_RATIO_64);
		end else begin
			unique case (r)
				SCM_RATE_32K:  ok = (n == SCM_RATIO_128);
				SCM_RATE_48K:  ok = (n == SCM_RATIO_128) || (n == SCM_RATIO_256) || (n == SCM_RATIO_512);
				SCM_RATE_96K:  ok = (n == SCM_RATIO_128) || (n == SCM_RATIO_256);
				SCM_RATE_192K: ok = (n == SCM_RATIO_128);
			endcase
		end
		return ok;
	endfunction

	// frame period in ref_clk cycles to rate family
	function automatic scm_rate_t rate_of(input logic [11:0] cyc);
		scm_rate_t r;
		if (cyc < SCM_F192_MAX_CYC) begin
			r = SCM_RATE_192K;
		end else if (cyc < SCM_F96_MAX_CYC) begin
			r = SCM_RATE_96K;
		end else if (cyc < SCM_F48_MAX_CYC) begin
			r = SCM_RATE_48K;
		end else begin
			r = SCM_RATE_32K;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////
	// pin synchronisers: {data, sync, bit clock}
	logic [2:0]  pin1_r;
	logic [2:0]  pin2_r;
	logic [2:0]  pin3_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin1_r <= 3'h0;
			pin2_r <= 3'h0;
			pin3_r <= 3'h0;
		end else begin
			pin1_r <= {serial_audio_in, word_frame_sync, serial_bit_clock};
			pin2_r <= pin1_r;
			pin3_r <= pin2_r;
		end
	end

	logic bclk_rise;
	logic bclk_edge;
	logic fs_now;
	logic din_now;
	assign bclk_rise = pin2_r[0] & ~pin3_r[0];
	assign bclk_edge = pin2_r[0] ^ pin3_r[0];
	assign fs_now    = pin2_r[1];
	assign din_now   = pin2_r[2];

	////////////////////////////////////////////////////////////////
	// frame, rate and halt tracking
	scm_state_t  state_r, state_nxt;
	logic        fs_prev_r, fs_prev_nxt;
	logic [9:0]  fbclk_r, fbclk_nxt;
	logic [11:0] fcyc_r, fcyc_nxt;
	logic [7:0]  bidle_r, bidle_nxt;
	logic [11:0] fidle_r, fidle_nxt;
	scm_rate_t   rate_r, rate_nxt;
	logic        ratio_err_r, ratio_err_nxt;
	logic        halt_r, halt_nxt;
	logic        err_r, err_nxt;
	logic        frame_start;
	logic        fs_change;
	logic        bclk_halt;
	logic        fs_halt;
	logic        halting;
	logic        rd_status;

	assign fs_change   = bclk_rise & (fs_now ^ fs_prev_r);
	assign frame_start = bclk_rise & fs_now & ~fs_prev_r;
	assign rd_status   = reg_rd & (reg_addr == SCM_STATUS_ADDR);
	// an edge or frame start in the timeout cycle ends that halt at once, so the
	// first frame after the clocks return already counts towards recovery
	assign bclk_halt   = (bidle_r == 8'(SCM_BCLK_TO_CYC)) & ~bclk_edge;
	assign fs_halt     = (fidle_r == 12'(SCM_FS_TO_CYC)) & ~frame_start;
	assign halting     = bclk_halt | fs_halt;

	always_comb begin
		state_nxt     = state_r;
		fs_prev_nxt   = bclk_rise ? fs_now : fs_prev_r;
		fbclk_nxt     = fbclk_r;
		fcyc_nxt      = (fcyc_r == 12'hFFF) ? fcyc_r : fcyc_r + 12'h001;
		bidle_nxt     = bclk_edge ? 8'h00 : (halting ? bidle_r : bidle_r + 8'h01);
		fidle_nxt     = frame_start ? 12'h000 : (halting ? fidle_r : fidle_r + 12'h001);
		rate_nxt      = rate_r;
		ratio_err_nxt = ratio_err_r;
		halt_nxt      = halt_r;
		err_nxt       = err_r;
		if (bclk_rise && fbclk_r != 10'h3FF) begin
			fbclk_nxt = fbclk_r + 10'h001;
		end
		// sticky error: a set later in this process beats the read clear
		if (rd_status) begin
			err_nxt = 1'b0;
		end
		if (halting) begin
			state_nxt = SCM_WAIT;
			halt_nxt  = 1'b1;
			err_nxt   = 1'b1;
		end else if (frame_start) begin
			fbclk_nxt = 10'h001;
			fcyc_nxt  = 12'h000;
			halt_nxt  = 1'b0;
			// lock on the first frame start, check the ratio from the second on
			unique case (state_r)
				SCM_WAIT: begin
					state_nxt = SCM_LOCK;
				end
				SCM_LOCK, SCM_RUN: begin
					rate_nxt = rate_of(fcyc_r);
					if (ratio_ok(tdm_mode, fbclk_r, rate_of(fcyc_r))) begin
						ratio_err_nxt = 1'b0;
						state_nxt     = SCM_RUN;
					end else begin
						ratio_err_nxt = 1'b1;
						err_nxt       = 1'b1;
						state_nxt     = SCM_LOCK;
					end
				end
				default: begin
					state_nxt = SCM_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r     <= SCM_WAIT;
			fs_prev_r   <= 1'b0;
			fbclk_r     <= 10'h000;
			fcyc_r      <= 12'h000;
			bidle_r     <= 8'h00;
			fidle_r     <= 12'h000;
			rate_r      <= SCM_RATE_48K;
			ratio_err_r <= 1'b0;
			halt_r      <= 1'b0;
			err_r       <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			fs_prev_r   <= fs_prev_nxt;
			fbclk_r     <= fbclk_nxt;
			fcyc_r      <= fcyc_nxt;
			bidle_r     <= bidle_nxt;
			fidle_r     <= fidle_nxt;
			rate_r      <= rate_nxt;
			ratio_err_r <= ratio_err_nxt;
			halt_r      <= halt_nxt;
			err_r       <= err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// serial data shifter and word framing
	logic [31:0] shift_r, shift_nxt;
	logic [5:0]  bitcnt_r, bitcnt_nxt;
	// 512 bit frames hold 16 slots of 32 bits
	logic [3:0]  slot_r, slot_nxt;
	scm_word_t   word_r, word_nxt;
	logic        wvalid_r, wvalid_nxt;
	logic        boundary;

	// two-channel: every sync change ends a word; TDM: frame rise or full word
	assign boundary = tdm_mode ? (frame_start | (bclk_rise & (bitcnt_r == SCM_WORD_BITS))) : fs_change;

	always_comb begin
		shift_nxt  = shift_r;
		bitcnt_nxt = bitcnt_r;
		slot_nxt   = slot_r;
		word_nxt   = word_r;
		wvalid_nxt = 1'b0;
		if (bclk_rise) begin
			shift_nxt  = {shift_r[30:0], din_now};
			bitcnt_nxt = (bitcnt_r == SCM_WORD_BITS) ? bitcnt_r : bitcnt_r + 6'h01;
		end
		if (boundary) begin
			word_nxt.data = shift_r;
			word_nxt.slot = slot_r;
			word_nxt.chan = fs_prev_r;
			// words pass only in run; the word that ends at the lock is not trusted
			wvalid_nxt    = (state_r == SCM_RUN) && (bitcnt_r != 6'h00);
			shift_nxt     = {31'h0, din_now};
			bitcnt_nxt    = 6'h01;
			slot_nxt      = (tdm_mode && !frame_start) ? slot_r + 4'h1 : 4'h0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			shift_r  <= 32'h0000_0000;
			bitcnt_r <= 6'h00;
			slot_r   <= 4'h0;
			word_r   <= '0;
			wvalid_r <= 1'b0;
		end else begin
			shift_r  <= shift_nxt;
			bitcnt_r <= bitcnt_nxt;
			slot_r   <= slot_nxt;
			word_r   <= word_nxt;
			wvalid_r <= wvalid_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// status register and outputs
	// halt and ratio are live, err holds until the status is read
	scm_status_t status;
	logic [7:0]  rdata_r, rdata_nxt;
	logic        tick_r, tick_nxt;
	logic        oe_n_r, oe_n_nxt;

	always_comb begin
		status       = '0;
		status.lock  = (state_r == SCM_RUN);
		status.rate  = rate_r;
		status.err   = err_r;
		status.ratio = ratio_err_r;
		status.halt  = halt_r;
		rdata_nxt    = rd_status ? status : (reg_rd ? SCM_STATUS_RESET : rdata_r);
		// the tick stands in for the loop output: one pulse per bit clock edge in run
		tick_nxt     = bclk_edge & (state_r == SCM_RUN);
		// from the next state, so outputs release in the cycle the halt is taken
		oe_n_nxt     = ~(play_enable & (state_nxt == SCM_RUN));
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= SCM_STATUS_RESET;
			tick_r  <= 1'b0;
			oe_n_r  <= 1'b1;
		end else begin
			rdata_r <= rdata_nxt;
			tick_r  <= tick_nxt;
			oe_n_r  <= oe_n_nxt;
		end
	end

	assign reg_rdata   = rdata_r;
	assign word_out    = word_r;
	assign word_valid  = wvalid_r;
	assign proc_tick   = tick_r;
	assign rate_family = rate_r;
	assign pll_locked  = (state_r == SCM_RUN);
	assign dsp_sleep   = (state_r != SCM_RUN);
	assign amp_oe_n    = oe_n_r;
endmodule

// ---- scm_pad_unused.sv ----
// spare file of the clock monitor, holds no logic

// ---- scm_monitor_chk.sv ----
// port assertions for the serial audio clock monitor
`timescale 1ns/1ns
module scm_monitor_chk
	import scm_pkg::*;
(
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       nrst,
	// watched ports
	input wire logic       serial_bit_clock,
	input wire logic       play_enable,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       word_valid,
	input wire logic       proc_tick,
	input wire logic       pll_locked,
	input wire logic       dsp_sleep,
	input wire logic       amp_oe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic       bclk_r;
	logic [7:0] idle_r;
	logic [7:0] idle_nxt;
	// cycles since the bit clock pin last moved, saturating
	always_comb begin
		idle_nxt = (serial_bit_clock != bclk_r) ? 8'h00 : idle_r + {7'h00, idle_r != 8'hFF};
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bclk_r <= 1'b0;
			idle_r <= 8'h00;
		end else begin
			bclk_r <= serial_bit_clock;
			idle_r <= idle_nxt;
		end
	end
	////////////////////////////////////////////////////////////////
	a_sleep_vs_lock: assert property (dsp_sleep == !pll_locked)
		else $error("sleep and lock disagree");
	a_drive_cause: assert property (!amp_oe_n |-> pll_locked && $past(play_enable))
		else $error("outputs driven without cause");
	a_tick_asleep: assert property (dsp_sleep |=> !proc_tick)
		else $error("tick while asleep");
	a_read_halt: assert property (reg_rd && reg_addr == SCM_STATUS_ADDR && idle_r >= 8'h6C
		|=> reg_rdata[SCM_ST_HALT_BIT])
		else $error("halt bit not set");
	a_word_in_run: assert property (word_valid |-> pll_locked || $past(pll_locked))
		else $error("word outside run");
	a_word_pulse: assert property (word_valid |=> !word_valid)
		else $error("word strobe too long");
	a_tick_pulse: assert property (proc_tick |=> !proc_tick)
		else $error("tick too long");
	a_halt_sleeps: assert property (idle_r >= 8'h6C |-> dsp_sleep && amp_oe_n)
		else $error("halt not seen");
	a_read_other: assert property (reg_rd && reg_addr != SCM_STATUS_ADDR |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_read_lock: assert property (reg_rd && reg_addr == SCM_STATUS_ADDR |=> reg_rdata[7] == $past(pll_locked))
		else $error("lock bit wrong");
endmodule

// ---- scm_host_model.sv ----
// audio source model: bit clock, sync and serial data
`timescale 1ns/1ns
module scm_host_model (
	// control from the bench
	input  wire logic        run,
	input  wire logic        tdm,
	input  wire logic [9:0]  bpf,
	input  wire logic [31:0] pat,
	// serial audio pins
	output logic             bclk,
	output logic             sync,
	output logic             sdata
);
	initial begin
		bclk = 1'b0;
		sync = 1'b0;
		sdata = 1'b0;
	end
	// one frame per pass; clock stands still while halted
	always begin
		if (!run) begin
			#80 sdata = ~sdata;
		end else begin
			for (int i = 0; i < int'(bpf); i++) begin
				sync = tdm ? (i == 0) : (i >= int'(bpf) / 2);
				sdata = pat[31 - (i % 32)];
				#80 bclk = 1'b1;
				#80 bclk = 1'b0;
			end
		end
	end
endmodule

// ---- scm_monitor_bench.sv ----
// self-checking bench for the serial audio clock monitor
`timescale 1ns/1ns
module scm_monitor_bench;
	import scm_pkg::*;
	typedef struct packed {logic tdm; logic [9:0] n; logic [1:0] rate; logic ok;} scm_case_t;
	scm_case_t   cases [6] = '{'{1'b0, 10'h020, 2'h3, 1'b1}, '{1'b0, 10'h040, 2'h2, 1'b1},
		'{1'b1, 10'h080, 2'h1, 1'b1}, '{1'b1, 10'h020, 2'h3, 1'b0}, '{1'b0, 10'h080, 2'h1, 1'b0},
		'{1'b1, 10'h0C8, 2'h0, 1'b0}};
	logic        timed_out = 1'b0;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        run = 1'b0;
	logic        tdm_mode = 1'b0;
	logic        play_enable = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [9:0]  bpf = 10'h040;
	logic [31:0] pat = 32'h0;
	logic [7:0]  reg_rdata, m;
	logic        bclk, sync, sdata, word_valid, proc_tick, pll_locked, dsp_sleep, amp_oe_n;
	scm_word_t   word_out;
	scm_rate_t   rate_family;
	int          num_errors = 0;
	int          check_count = 0;
	integer      seed = 32'h22D1B92E;

	always #10 ref_clk = ~ref_clk;

	scm_host_model host (.run(run), .tdm(tdm_mode), .bpf(bpf), .pat(pat), .bclk(bclk), .sync(sync), .sdata(sdata));
	scm_monitor uut (.ref_clk, .nrst, .serial_bit_clock(bclk), .word_frame_sync(sync), .serial_audio_in(sdata),
		.tdm_mode, .play_enable, .reg_addr, .reg_rd, .reg_rdata, .word_out, .word_valid, .proc_tick,
		.rate_family, .pll_locked, .dsp_sleep, .amp_oe_n);
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_status(input scm_case_t c);
		return {c.ok, c.rate, 1'b0, 1'b0, !c.ok, 2'b00};
	endfunction
	// two-channel 32 bit frames carry 16 bit halves, right aligned
	function automatic logic [31:0] exp_word(input logic [9:0] n, input logic c, input logic [31:0] p);
		return (n != 10'h020) ? p : (c ? {16'h0000, p[15:0]} : {16'h0000, p[31:16]});
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		#2 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#2 reg_rd = 1'b0;
		@(posedge ref_clk);
		#2;
	endtask
	// bounded wait on lock or on a word strobe
	task automatic wait_for(input logic w);
		for (int i = 0; i < 8000 && (w ? word_valid : pll_locked) !== 1'b1; i++) begin
			@(posedge ref_clk);
			#2;
		end
		if ((w ? word_valid : pll_locked) !== 1'b1) begin
			timed_out = 1'b1;
			chk(32'h0, 32'h1);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge ref_clk);
		chk(32'({dsp_sleep, amp_oe_n, pll_locked, rate_family, word_valid}), 32'h32);
		#2 nrst = 1'b1;
		foreach (cases[k]) begin
			if (timed_out) break;
			run = 1'b0;
			repeat (5000) @(posedge ref_clk);
			rd(SCM_STATUS_ADDR);
			chk(32'(reg_rdata & 8'h8A), 32'h0A);
			chk(32'({dsp_sleep, amp_oe_n}), 32'h3);
			rd(8'($random(seed)) | 8'h80);
			chk(32'(reg_rdata), 32'h0);
			tdm_mode = cases[k].tdm;
			bpf = cases[k].n;
			pat = $random(seed);
			play_enable = 1'($random(seed));
			run = 1'b1;
			if (cases[k].ok) wait_for(1'b0);
			else repeat (4000) @(posedge ref_clk);
			rd(SCM_STATUS_ADDR);
			m = cases[k].ok ? 8'hF7 : 8'hE4;
			chk(32'(reg_rdata & m), 32'(exp_status(cases[k]) & m));
			chk(32'(amp_oe_n), 32'(!(play_enable && cases[k].ok)));
			if (cases[k].ok) begin
				chk(32'(rate_family), 32'(cases[k].rate));
				rd(SCM_STATUS_ADDR);
				chk(32'(reg_rdata), 32'(exp_status(cases[k])));
				wait_for(1'b1);
				chk(word_out.data, exp_word(cases[k].n, word_out.chan, pat));
				chk(32'({word_out.chan, word_out.slot}), 32'({!cases[k].tdm, 4'h0}));
			end
		end
		// reset in mid-run with the clocks still running
		#2 nrst = 1'b0;
		@(posedge ref_clk);
		chk(32'({dsp_sleep, amp_oe_n, pll_locked, rate_family, word_valid}), 32'h32);
		#2 nrst = 1'b1;
		rd(SCM_STATUS_ADDR);
		chk(32'(reg_rdata), 32'h20);
		chk(32'({dsp_sleep, amp_oe_n, pll_locked, rate_family, word_valid}), 32'h32);
		end_of_test;
	end
endmodule

bind scm_monitor scm_monitor_chk chk (.ref_clk, .nrst, .serial_bit_clock, .play_enable, .reg_addr, .reg_rd,
	.reg_rdata, .word_valid, .proc_tick, .pll_locked, .dsp_sleep, .amp_oe_n);
